// ### design/port_pin_data.sv
// Purpose: port pin data register with read-back and pin steering
// Assumes: inputs synchronous to clk_i; cpu access is one-cycle strobe
// Notes: only power-on reset clears the register; manual reset does not

// ============================================================
// How it works
// - sixteen-bit read/write register, bit n per pin
// - port-function output pins driven from stored data bits; timer and pattern pins from their own sources
// - direction one reads back stored bit
// - direction zero reads sampled pin level
// - input or peripheral pins: store only, pin unchanged
// - enabled pattern-output pins ignore data writes
// - power-on reset clears all bits
// - manual reset, standby, sleep keep contents
// - fixed address, byte, halfword, word accesses
// - select: 00 port, 10 timer, 11 pattern
module port_pin_data (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic manual_reset_i,
   input wire logic standby_i,
   input wire logic sleep_i,
   input wire logic acc_valid_i,
   input wire logic acc_write_i,
   input wire logic [27:0] acc_addr_i,
   input wire logic [1:0] acc_size_i,
   input wire logic [31:0] acc_wdata_i,
   output logic [31:0] acc_rdata_o,
   output logic acc_hit_o,
   input wire logic [15:0] pin_direction_bits_i,
   input wire logic [31:0] pin_function_select_i,
   input wire logic [15:0] next_data_enable_i,
   input wire logic [15:0] timing_pattern_output_i,
   input wire logic [15:0] timer_out_i,
   input wire logic [15:0] timer_oe_i,
   input wire logic [15:0] pin_in_i,
   output logic [15:0] pin_out_o,
   output logic [15:0] pin_oe_o
);
   // ============================================================
   // helpers
   // two-bit select field of pin n
   function automatic logic [1:0] func_of(input logic [31:0] sel,
                                          input int n);
      return sel[2*n +: 2];
   endfunction

   // byte lanes an access covers; big-endian, so the even byte is high
   function automatic logic [15:0] lane_mask(input logic [1:0] size,
                                             input logic odd);
      logic [15:0] mask;
      mask = 16'h0000;
      case (size)
         port_pkg::SIZE_BYTE: mask = odd ? 16'h00ff : 16'hff00;
         // odd halfword is refused, never split over two lanes
         port_pkg::SIZE_HALF: mask = odd ? 16'h0000 : 16'hffff;
         port_pkg::SIZE_WORD: mask = 16'hffff;
         default: mask = 16'h0000;
      endcase
      return mask;
   endfunction

   // read data placed in the low bits of the bus
   function automatic logic [31:0] read_lane(input logic [15:0] value,
                                             input logic [1:0] size,
                                             input logic odd);
      logic [31:0] word;
      word = {16'h0000, value};
      if (size == port_pkg::SIZE_BYTE)
         word = {24'h000000, odd ? value[7:0] : value[15:8]};
      return word;
   endfunction

   // ============================================================
   // decode
   logic reg_half_addr;
   logic reg_word_addr;
   logic word_hit;
   logic half_hit;
   logic [15:0] lane_en;
   logic [15:0] lane_data;
   logic [15:0] pattern_lock;
   logic [15:0] write_mask;
   logic wr_en;
   logic rd_en;
   logic [15:0] read_value;
   logic [15:0] port_pin_data_ff;
   logic [15:0] nxt_port_pin_data;
   logic [31:0] acc_rdata_ff;
   logic [31:0] nxt_acc_rdata;

   // halfword at c2 covers bytes c2 and c3
   assign reg_half_addr = acc_addr_i[27:1] ==
      port_pkg::PORT_PIN_DATA_ADDR[27:1];
   // long access only on the aligned word; its low half is this register
   assign reg_word_addr = acc_addr_i ==
      (port_pkg::PORT_PIN_DATA_ADDR & port_pkg::WORD_ALIGN_MASK);

   always_comb begin
      half_hit = acc_valid_i && reg_half_addr &&
         acc_size_i != port_pkg::SIZE_WORD;
      word_hit = acc_valid_i && reg_word_addr &&
         acc_size_i == port_pkg::SIZE_WORD;
      lane_en = 16'h0000;
      if (half_hit || word_hit)
         lane_en = lane_mask(acc_size_i, acc_addr_i[0]);
      // byte data arrives in bits 7:0 and is copied to both lanes
      lane_data = acc_wdata_i[15:0];
      if (acc_size_i == port_pkg::SIZE_BYTE)
         lane_data = {acc_wdata_i[7:0], acc_wdata_i[7:0]};
   end

   assign acc_hit_o = |lane_en;
   assign wr_en = acc_hit_o && acc_write_i;
   assign rd_en = acc_hit_o && !acc_write_i;

   // ============================================================
   // register update
   always_comb begin
      for (int n = 0; n < port_pkg::PIN_COUNT; n++)
         pattern_lock[n] = func_of(pin_function_select_i, n) ==
            port_pkg::FUNC_PATTERN && next_data_enable_i[n];
      // other pins take the write whatever their function
      write_mask = lane_en & ~pattern_lock;
      nxt_port_pin_data = port_pin_data_ff;
      // low-power and manual reset inputs never touch the bits
      if (wr_en) begin
         nxt_port_pin_data = (port_pin_data_ff & ~write_mask) |
            (lane_data & write_mask);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         port_pin_data_ff <= port_pkg::PORT_PIN_DATA_RESET;
      else
         port_pin_data_ff <= nxt_port_pin_data;
   end

   // ============================================================
   // read path
   always_comb begin
      // function select plays no part in read-back
      read_value = (port_pin_data_ff & pin_direction_bits_i) |
         (pin_in_i & ~pin_direction_bits_i);
      nxt_acc_rdata = 32'h00000000;
      // data stands one cycle only; idle cycles return zero
      if (rd_en)
         nxt_acc_rdata = read_lane(read_value, acc_size_i, acc_addr_i[0]);
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         acc_rdata_ff <= 32'h00000000;
      else
         acc_rdata_ff <= nxt_acc_rdata;
   end

   assign acc_rdata_o = acc_rdata_ff;

   // ============================================================
   // pin multiplexer
   pin_mux_if mux_bus ();

   assign mux_bus.stored = port_pin_data_ff;
   assign mux_bus.direction = pin_direction_bits_i;
   assign mux_bus.func_sel = pin_function_select_i;
   assign mux_bus.pattern_val = timing_pattern_output_i;
   assign mux_bus.timer_val = timer_out_i;
   assign mux_bus.timer_oe = timer_oe_i;

   pin_mux u_pin_mux (
      .mux(mux_bus.mux_side)
   );

   assign pin_out_o = mux_bus.pin_out;
   assign pin_oe_o = mux_bus.pin_oe;
endmodule

// ### design/port_pkg.sv
// Purpose: constants shared by the port pin data block
// Assumes: one 200 MHz clock, async active-low reset
// Notes: register reached over the documented cpu-side access port
package port_pkg;
   localparam int unsigned PIN_COUNT = 16;
   localparam logic [27:0] PORT_PIN_DATA_ADDR = 28'h5ffffc2;
   localparam logic [27:0] WORD_ALIGN_MASK = 28'hffffffc;
   localparam logic [15:0] PORT_PIN_DATA_RESET = 16'h0000;
   // access sizes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   // per-pin function select codes
   localparam logic [1:0] FUNC_PORT = 2'h0;
   localparam logic [1:0] FUNC_RESERVED = 2'h1;
   localparam logic [1:0] FUNC_TIMER = 2'h2;
   localparam logic [1:0] FUNC_PATTERN = 2'h3;
endpackage

// ### design/pin_mux_if.sv
// Purpose: bundle between data register and pin multiplexer
// Assumes: port_pkg compiled first
// Notes: one bit per pin in every field except func_sel, which has two bits per pin
interface pin_mux_if;
   logic [15:0] stored;
   logic [15:0] direction;
   logic [31:0] func_sel;
   logic [15:0] pattern_val;
   logic [15:0] timer_val;
   logic [15:0] timer_oe;
   logic [15:0] pin_out;
   logic [15:0] pin_oe;
   modport reg_side (output stored, direction, func_sel, pattern_val,
      timer_val, timer_oe, input pin_out, pin_oe);
   modport mux_side (input stored, direction, func_sel, pattern_val,
      timer_val, timer_oe, output pin_out, pin_oe);
endinterface

// ### design/pin_mux.sv
// Purpose: per-pin output multiplexer for the port pins
// Assumes: select codes from port_pkg
// Notes: purely combinational; the pin sampling is done upstream
module pin_mux (
   pin_mux_if.mux_side mux
);
   always_comb begin
      for (int n = 0; n < port_pkg::PIN_COUNT; n++) begin
         logic [1:0] sel;
         sel = mux.func_sel[2*n +: 2];
         mux.pin_out[n] = 1'b0;
         mux.pin_oe[n] = 1'b0;
         case (sel)
            port_pkg::FUNC_PORT: begin
               mux.pin_out[n] = mux.stored[n];
               mux.pin_oe[n] = mux.direction[n];
            end
            port_pkg::FUNC_TIMER: begin
               // stored bit does not reach the pin
               mux.pin_out[n] = mux.timer_val[n];
               mux.pin_oe[n] = mux.timer_oe[n];
            end
            port_pkg::FUNC_PATTERN: begin
               mux.pin_out[n] = mux.pattern_val[n];
               mux.pin_oe[n] = mux.direction[n];
            end
            default: begin
               // reserved code leaves the pin undriven
               mux.pin_out[n] = 1'b0;
               mux.pin_oe[n] = 1'b0;
            end
         endcase
      end
   end
endmodule

// ### test/port_pin_data_props.sv
// Purpose: concurrent checks on the pin data register ports
// Assumes: one clock, async active-low power-on reset
// Notes: watches pin 0 for drive enables to keep the checks cheap
module port_pin_data_props (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic acc_valid_i,
   input wire logic acc_write_i,
   input wire logic [27:0] acc_addr_i,
   input wire logic [1:0] acc_size_i,
   input wire logic [31:0] acc_wdata_i,
   input wire logic [31:0] acc_rdata_o,
   input wire logic acc_hit_o,
   input wire logic [15:0] pin_direction_bits_i,
   input wire logic [31:0] pin_function_select_i,
   input wire logic [15:0] next_data_enable_i,
   input wire logic [15:0] pin_in_i,
   input wire logic [15:0] pin_out_o,
   input wire logic [15:0] pin_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // plain output setup: all outputs, port function, no pattern
   wire logic cfg_w = pin_direction_bits_i == 16'hffff &&
      pin_function_select_i == 32'h0 && next_data_enable_i == 16'h0;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence half_s;
      acc_valid_i && acc_size_i == port_pkg::SIZE_HALF &&
         acc_addr_i == port_pkg::PORT_PIN_DATA_ADDR;
   endsequence
   sequence rd_s;
      half_s ##0 !acc_write_i;
   endsequence
   hit_half_a: assert property (half_s |-> acc_hit_o)
      else $error("halfword access missed");
   odd_miss_a: assert property (acc_valid_i &&
      acc_addr_i == 28'h5ffffc1 && acc_size_i == port_pkg::SIZE_HALF
      |-> !acc_hit_o) else $error("odd halfword accepted");
   word_odd_a: assert property (acc_valid_i &&
      acc_size_i == port_pkg::SIZE_WORD && acc_addr_i[1:0] != 2'h0 |->
      !acc_hit_o) else $error("misaligned word accepted");
   rdata_idle_a: assert property (!(acc_valid_i && !acc_write_i &&
      acc_hit_o) |=> acc_rdata_o == 32'h0) else $error("stray read data");
   read_pin_a: assert property (rd_s |=> ((acc_rdata_o[15:0] ^
      $past(pin_in_i)) & ~$past(pin_direction_bits_i)) == 16'h0)
      else $error("input pin read wrong");
   read_reg_a: assert property (rd_s ##0 cfg_w |=>
      acc_rdata_o[15:0] == $past(pin_out_o)) else $error("stored read");
   write_out_a: assert property (half_s ##0 acc_write_i && cfg_w |=>
      pin_out_o == $past(acc_wdata_i[15:0])) else $error("pin not driven");
   drive_oe_a: assert property (pin_direction_bits_i[0] &&
      pin_function_select_i[1:0] == 2'h0 |-> pin_oe_o[0])
      else $error("output pin not enabled");
   input_hiz_a: assert property (!pin_direction_bits_i[0] &&
      pin_function_select_i[1:0] == 2'h0 |-> !pin_oe_o[0])
      else $error("input pin driven");
   data_hold_a: assert property ((!acc_valid_i && cfg_w) ##1 cfg_w |->
      $stable(pin_out_o)) else $error("data lost without write");
endmodule

bind port_pin_data port_pin_data_props props_i (.clk_i, .rst_b_i,
   .acc_valid_i, .acc_write_i, .acc_addr_i, .acc_size_i, .acc_wdata_i,
   .acc_rdata_o, .acc_hit_o, .pin_direction_bits_i, .pin_function_select_i,
   .next_data_enable_i, .pin_in_i, .pin_out_o, .pin_oe_o);

// ### test/port_pin_data_tb.sv
// Purpose: directed test of the pin data register
// Assumes: design package compiled first
// Notes: all stimulus on the rising edge by non-blocking assignment
module port_pin_data_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_b_i = 1'b0, m_i = 1'b0, sb_i = 1'b0, sl_i = 1'b0;
   logic v_i = 1'b0, w_i = 1'b0;
   logic [27:0] a_i = 28'h0;
   logic [1:0] s_i = 2'h0;
   logic [31:0] d_i = 32'h0, fs_i = 32'h0, rdata_o;
   logic [15:0] dir_i = 16'hffff, nde_i = 16'h0, tp_i = 16'h0f0f;
   logic [15:0] to_i = 16'h0, toe_i = 16'h0, in_i = 16'h0, out_o, oe_o;
   int n_errors = 0, compares = 0;
   always #2.5 clk_i = ~clk_i;
   port_pin_data DUT (.clk_i, .rst_b_i, .manual_reset_i(m_i),
      .standby_i(sb_i), .sleep_i(sl_i), .acc_valid_i(v_i), .acc_write_i(w_i),
      .acc_addr_i(a_i), .acc_size_i(s_i), .acc_wdata_i(d_i),
      .acc_rdata_o(rdata_o), .acc_hit_o(), .pin_direction_bits_i(dir_i),
      .pin_function_select_i(fs_i), .next_data_enable_i(nde_i),
      .timing_pattern_output_i(tp_i), .timer_out_i(to_i),
      .timer_oe_i(toe_i), .pin_in_i(in_i), .pin_out_o(out_o),
      .pin_oe_o(oe_o));
   // ==========================================================
   // access tasks
   task automatic chk(input string nm, input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one-cycle strobe; the edge after it carries the answer
   task automatic acc(input logic w, input logic [27:0] a,
      input logic [1:0] s, input logic [31:0] d);
      @(posedge clk_i);
      v_i <= 1'b1;
      w_i <= w;
      a_i <= a;
      s_i <= s;
      d_i <= d;
      @(posedge clk_i);
      v_i <= 1'b0;
   endtask
   task automatic rd(input logic [27:0] a, input logic [1:0] s,
      input logic [31:0] exp, input string nm);
      acc(1'b0, a, s, 32'h0);
      #1 chk(nm, rdata_o, exp);
   endtask
   task automatic cfg(input logic [15:0] dir, input logic [31:0] fs,
      input logic [15:0] nde);
      @(posedge clk_i);
      dir_i <= dir;
      fs_i <= fs;
      nde_i <= nde;
      @(posedge clk_i);
      #1;
   endtask
   task automatic wrap_up;
      if (n_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'h0, "reset value");
      acc(1'b1, 28'h5ffffc2, port_pkg::SIZE_HALF, 32'h1234);
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'h1234, "half rw");
      chk("pin out", {16'h0, out_o}, 32'h1234);
      acc(1'b1, 28'h5ffffc3, port_pkg::SIZE_BYTE, 32'hab);
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'h12ab, "low lane");
      acc(1'b1, 28'h5ffffc2, port_pkg::SIZE_BYTE, 32'hcd);
      rd(28'h5ffffc3, port_pkg::SIZE_BYTE, 32'hab, "byte read");
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'hcdab, "high lane");
      acc(1'b1, 28'h5ffffc0, port_pkg::SIZE_WORD, 32'h5a5a);
      rd(28'h5ffffc0, port_pkg::SIZE_WORD, 32'h5a5a, "word rw");
      rd(28'h5ffffc6, port_pkg::SIZE_HALF, 32'h0, "unmapped");
      // misaligned long access is refused both ways
      acc(1'b1, 28'h5ffffc2, port_pkg::SIZE_WORD, 32'h1111);
      rd(28'h5ffffc2, port_pkg::SIZE_WORD, 32'h0, "odd word");
      @(posedge clk_i);
      m_i <= 1'b1;
      sb_i <= 1'b1;
      sl_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      m_i <= 1'b0;
      sb_i <= 1'b0;
      sl_i <= 1'b0;
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'h5a5a, "retained");
      @(posedge clk_i);
      in_i <= 16'h0f0f;
      cfg(16'h0, 32'h0, 16'h0);
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'h0f0f, "pin read");
      chk("input oe", {16'h0, oe_o}, 32'h0);
      acc(1'b1, 28'h5ffffc2, port_pkg::SIZE_HALF, 32'hffff);
      cfg(16'hffff, 32'h0, 16'h0);
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'hffff, "input store");
      // low byte held by enabled pattern output
      cfg(16'hffff, 32'hffffffff, 16'h00ff);
      acc(1'b1, 28'h5ffffc2, port_pkg::SIZE_HALF, 32'h0);
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'h00ff, "pattern");
      chk("pattern pin", {16'h0, out_o}, 32'h0f0f);
      // pattern select without its enable still takes writes
      cfg(16'hffff, 32'hffffffff, 16'h0);
      acc(1'b1, 28'h5ffffc2, port_pkg::SIZE_HALF, 32'h1111);
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'h1111, "pattern off");
      @(posedge clk_i);
      to_i <= 16'ha5a5;
      toe_i <= 16'hffff;
      cfg(16'hffff, 32'haaaaaaaa, 16'h0);
      chk("timer pin", {16'h0, out_o}, 32'ha5a5);
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'h1111, "timer read");
      cfg(16'hffff, 32'h55555555, 16'h0);
      chk("reserved oe", {16'h0, oe_o}, 32'h0);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      cfg(16'hffff, 32'h0, 16'h0);
      @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(28'h5ffffc2, port_pkg::SIZE_HALF, 32'h0, "power-on");
      wrap_up();
   end
   // whole run needs well under a thousand cycles
   initial begin
      #20000;
      n_errors++;
      wrap_up();
   end
endmodule
